/* File: ifeb_bank.sv */
`timescale 1ns/10ps
`default_nettype none

module ifeb_bank (
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        rst,
    // Register port.
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [15:0] reg_rdata,
    // Peripheral request pulses, one vector per flag register.
    input  wire logic [15:0] src_req_1,
    input  wire logic [15:0] src_req_2,
    input  wire logic [15:0] src_req_3,
    input  wire logic [15:0] src_req_4,
    input  wire logic [15:0] src_req_5,
    // Pending requests toward priority arbitration.
    output logic      [15:0] pending_1,
    output logic      [15:0] pending_2
);

    logic [15:0] flags_1_q;
    logic [15:0] flags_2_q;
    logic [15:0] flags_3_q;
    logic [15:0] flags_4_q;
    logic [15:0] flags_5_q;
    logic [15:0] enables_0_q;
    logic [15:0] enables_1_q;
    logic [15:0] enables_2_q;
    logic [15:0] reg_rdata_q;
    logic [15:0] pending_1_q;
    logic [15:0] pending_2_q;

    // Write strobes per register.
    wire sel_f1 = reg_write && (reg_addr == ifeb_pkg::ADDR_FLAGS_1);
    wire sel_f2 = reg_write && (reg_addr == ifeb_pkg::ADDR_FLAGS_2);
    wire sel_f3 = reg_write && (reg_addr == ifeb_pkg::ADDR_FLAGS_3);
    wire sel_f4 = reg_write && (reg_addr == ifeb_pkg::ADDR_FLAGS_4);
    wire sel_f5 = reg_write && (reg_addr == ifeb_pkg::ADDR_FLAGS_5);
    wire sel_e0 = reg_write && (reg_addr == ifeb_pkg::ADDR_ENABLES_0);
    wire sel_e1 = reg_write && (reg_addr == ifeb_pkg::ADDR_ENABLES_1);
    wire sel_e2 = reg_write && (reg_addr == ifeb_pkg::ADDR_ENABLES_2);
    wire [15:0] no_set = 16'h0000;

    // Flag registers: hardware sets, software writes; masks fix the layouts.
    ifeb_reg16 #(.MASK(ifeb_pkg::MASK_FLAGS_1)) u_flags_1 (
        .clock(clock), .rst(rst), .wr_en(sel_f1), .wr_data(reg_wdata),
        .hw_set(src_req_1), .value_q(flags_1_q));
    ifeb_reg16 #(.MASK(ifeb_pkg::MASK_FLAGS_2)) u_flags_2 (
        .clock(clock), .rst(rst), .wr_en(sel_f2), .wr_data(reg_wdata),
        .hw_set(src_req_2), .value_q(flags_2_q));
    ifeb_reg16 #(.MASK(ifeb_pkg::MASK_FLAGS_3)) u_flags_3 (
        .clock(clock), .rst(rst), .wr_en(sel_f3), .wr_data(reg_wdata),
        .hw_set(src_req_3), .value_q(flags_3_q));
    ifeb_reg16 #(.MASK(ifeb_pkg::MASK_FLAGS_4)) u_flags_4 (
        .clock(clock), .rst(rst), .wr_en(sel_f4), .wr_data(reg_wdata),
        .hw_set(src_req_4), .value_q(flags_4_q));
    ifeb_reg16 #(.MASK(ifeb_pkg::MASK_FLAGS_5)) u_flags_5 (
        .clock(clock), .rst(rst), .wr_en(sel_f5), .wr_data(reg_wdata),
        .hw_set(src_req_5), .value_q(flags_5_q));

    // Enable registers are written only by software.
    ifeb_reg16 #(.MASK(ifeb_pkg::MASK_ENABLES_0)) u_enables_0 (
        .clock(clock), .rst(rst), .wr_en(sel_e0), .wr_data(reg_wdata),
        .hw_set(no_set), .value_q(enables_0_q));
    ifeb_reg16 #(.MASK(ifeb_pkg::MASK_ENABLES_1)) u_enables_1 (
        .clock(clock), .rst(rst), .wr_en(sel_e1), .wr_data(reg_wdata),
        .hw_set(no_set), .value_q(enables_1_q));
    ifeb_reg16 #(.MASK(ifeb_pkg::MASK_ENABLES_2)) u_enables_2 (
        .clock(clock), .rst(rst), .wr_en(sel_e2), .wr_data(reg_wdata),
        .hw_set(no_set), .value_q(enables_2_q));

    // Read decode; unmapped addresses and reserved bits return zero.
    wire [15:0] rd_mux =
        (reg_addr == ifeb_pkg::ADDR_FLAGS_1)   ? flags_1_q :
        (reg_addr == ifeb_pkg::ADDR_FLAGS_2)   ? flags_2_q :
        (reg_addr == ifeb_pkg::ADDR_FLAGS_3)   ? flags_3_q :
        (reg_addr == ifeb_pkg::ADDR_FLAGS_4)   ? flags_4_q :
        (reg_addr == ifeb_pkg::ADDR_FLAGS_5)   ? flags_5_q :
        (reg_addr == ifeb_pkg::ADDR_ENABLES_0) ? enables_0_q :
        (reg_addr == ifeb_pkg::ADDR_ENABLES_1) ? enables_1_q :
        (reg_addr == ifeb_pkg::ADDR_ENABLES_2) ? enables_2_q : 16'h0000;

    // Pending requests: flag and enable for the two register pairs that share layouts.
    // Flag 1 pairs with enable 1 and flag 2 with enable 2; flags stay until cleared.
    wire [15:0] pend_1_d = flags_1_q & enables_1_q;
    wire [15:0] pend_2_d = flags_2_q & enables_2_q;

    // Read data is valid only in the cycle after the read strobe.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata_q <= 16'h0000;
            pending_1_q <= 16'h0000;
            pending_2_q <= 16'h0000;
        end else begin
            reg_rdata_q <= reg_read ? rd_mux : 16'h0000;
            pending_1_q <= pend_1_d;
            pending_2_q <= pend_2_d;
        end
    end

    assign reg_rdata = reg_rdata_q;
    assign pending_1 = pending_1_q;
    assign pending_2 = pending_2_q;

    // Reserved positions in flags one and five never read one.
    a_flag_mask_zero: assert property (@(posedge clock) disable iff (rst)
        (flags_1_q & ~ifeb_pkg::MASK_FLAGS_1) == 16'h0000 &&
        (flags_5_q & ~ifeb_pkg::MASK_FLAGS_5) == 16'h0000)
        else $error("reserved flag bit set");

    // A request pulse shows up in the flag one cycle later.
    a_flag_sets: assert property (@(posedge clock) disable iff (rst)
        src_req_1[ifeb_pkg::TIMER4_FLAG_BIT] |=> flags_1_q[ifeb_pkg::TIMER4_FLAG_BIT])
        else $error("timer4 flag not set");

    // Without set or write the flag holds.
    a_flag_holds: assert property (@(posedge clock) disable iff (rst)
        !sel_f2 |=> flags_2_q == ($past(flags_2_q) | $past(src_req_2 & ifeb_pkg::MASK_FLAGS_2)))
        else $error("flag two changed without cause");

    // Software write lands in enable zero.
    a_enable_write: assert property (@(posedge clock) disable iff (rst)
        sel_e0 |=> enables_0_q == ($past(reg_wdata) & ifeb_pkg::MASK_ENABLES_0))
        else $error("enable zero write lost");

    // Pending follows flag and enable one cycle on.
    a_pending_gate: assert property (@(posedge clock) disable iff (rst)
        ##1 pending_1 == $past(flags_1_q & enables_1_q))
        else $error("pending one wrong");

    // Read data appears one cycle after the strobe.
    a_read_data: assert property (@(posedge clock) disable iff (rst)
        reg_read && reg_addr == ifeb_pkg::ADDR_ENABLES_2 |=> reg_rdata == $past(enables_2_q))
        else $error("read data wrong");

    // Unmapped reads return zero.
    a_unmapped_zero: assert property (@(posedge clock) disable iff (rst)
        reg_read && reg_addr == 4'h0 |=> reg_rdata == 16'h0000)
        else $error("unmapped read nonzero");

    // Flag five only ever holds the usb bit.
    a_usb_only: assert property (@(posedge clock) disable iff (rst)
        src_req_5[ifeb_pkg::USB_OTG_FLAG_BIT] && !sel_f5 |=> flags_5_q == 16'h0040)
        else $error("usb flag layout wrong");

    // Each register reads back what it holds, one cycle after the strobe.
    a_read_flag_one: assert property (@(posedge clock) disable iff (rst)
        reg_read && reg_addr == ifeb_pkg::ADDR_FLAGS_1 |=> reg_rdata == $past(flags_1_q))
        else $error("flag one read wrong");
    a_read_flag_two: assert property (@(posedge clock) disable iff (rst)
        reg_read && reg_addr == ifeb_pkg::ADDR_FLAGS_2 |=> reg_rdata == $past(flags_2_q))
        else $error("flag two read wrong");
    a_read_flag_three: assert property (@(posedge clock) disable iff (rst)
        reg_read && reg_addr == ifeb_pkg::ADDR_FLAGS_3 |=> reg_rdata == $past(flags_3_q))
        else $error("flag three read wrong");
    a_read_flag_four: assert property (@(posedge clock) disable iff (rst)
        reg_read && reg_addr == ifeb_pkg::ADDR_FLAGS_4 |=> reg_rdata == $past(flags_4_q))
        else $error("flag four read wrong");
    a_read_flag_five: assert property (@(posedge clock) disable iff (rst)
        reg_read && reg_addr == ifeb_pkg::ADDR_FLAGS_5 |=> reg_rdata == $past(flags_5_q))
        else $error("flag five read wrong");
    a_read_enable_zero: assert property (@(posedge clock) disable iff (rst)
        reg_read && reg_addr == ifeb_pkg::ADDR_ENABLES_0 |=> reg_rdata == $past(enables_0_q))
        else $error("enable zero read wrong");
    a_read_enable_one: assert property (@(posedge clock) disable iff (rst)
        reg_read && reg_addr == ifeb_pkg::ADDR_ENABLES_1 |=> reg_rdata == $past(enables_1_q))
        else $error("enable one read wrong");

    // A software write lands masked; a request in the same cycle still sets its flag.
    a_write_flag_one: assert property (@(posedge clock) disable iff (rst)
        sel_f1 |=> flags_1_q == (($past(reg_wdata) | $past(src_req_1)) & ifeb_pkg::MASK_FLAGS_1))
        else $error("flag one write wrong");
    a_write_flag_two: assert property (@(posedge clock) disable iff (rst)
        sel_f2 |=> flags_2_q == (($past(reg_wdata) | $past(src_req_2)) & ifeb_pkg::MASK_FLAGS_2))
        else $error("flag two write wrong");
    a_write_flag_three: assert property (@(posedge clock) disable iff (rst)
        sel_f3 |=> flags_3_q == (($past(reg_wdata) | $past(src_req_3)) & ifeb_pkg::MASK_FLAGS_3))
        else $error("flag three write wrong");
    a_write_flag_four: assert property (@(posedge clock) disable iff (rst)
        sel_f4 |=> flags_4_q == (($past(reg_wdata) | $past(src_req_4)) & ifeb_pkg::MASK_FLAGS_4))
        else $error("flag four write wrong");
    a_write_flag_five: assert property (@(posedge clock) disable iff (rst)
        sel_f5 |=> flags_5_q == (($past(reg_wdata) | $past(src_req_5)) & ifeb_pkg::MASK_FLAGS_5))
        else $error("flag five write wrong");
    a_write_enable_one: assert property (@(posedge clock) disable iff (rst)
        sel_e1 |=> enables_1_q == ($past(reg_wdata) & ifeb_pkg::MASK_ENABLES_1))
        else $error("enable one write lost");
    a_write_enable_two: assert property (@(posedge clock) disable iff (rst)
        sel_e2 |=> enables_2_q == ($past(reg_wdata) & ifeb_pkg::MASK_ENABLES_2))
        else $error("enable two write lost");

    // Without a write a flag only gains bits, so a pending event is never dropped.
    a_hold_flag_one: assert property (@(posedge clock) disable iff (rst)
        !sel_f1 |=> flags_1_q == ($past(flags_1_q) | $past(src_req_1 & ifeb_pkg::MASK_FLAGS_1)))
        else $error("flag one changed without cause");
    a_hold_flag_three: assert property (@(posedge clock) disable iff (rst)
        !sel_f3 |=> flags_3_q == ($past(flags_3_q) | $past(src_req_3 & ifeb_pkg::MASK_FLAGS_3)))
        else $error("flag three changed without cause");
    a_hold_flag_four: assert property (@(posedge clock) disable iff (rst)
        !sel_f4 |=> flags_4_q == ($past(flags_4_q) | $past(src_req_4 & ifeb_pkg::MASK_FLAGS_4)))
        else $error("flag four changed without cause");
    a_hold_flag_five: assert property (@(posedge clock) disable iff (rst)
        !sel_f5 |=> flags_5_q == ($past(flags_5_q) | $past(src_req_5 & ifeb_pkg::MASK_FLAGS_5)))
        else $error("flag five changed without cause");

    // Enables change only under a software write to their own index.
    a_hold_enable_zero: assert property (@(posedge clock) disable iff (rst)
        !sel_e0 |=> $stable(enables_0_q))
        else $error("enable zero changed without write");
    a_hold_enable_one: assert property (@(posedge clock) disable iff (rst)
        !sel_e1 |=> $stable(enables_1_q))
        else $error("enable one changed without write");
    a_hold_enable_two: assert property (@(posedge clock) disable iff (rst)
        !sel_e2 |=> $stable(enables_2_q))
        else $error("enable two changed without write");

    // Reserved positions stay zero in the remaining flags and in every enable.
    a_flag_mask_rest: assert property (@(posedge clock) disable iff (rst)
        (flags_2_q & ~ifeb_pkg::MASK_FLAGS_2) == 16'h0000 &&
        (flags_3_q & ~ifeb_pkg::MASK_FLAGS_3) == 16'h0000 &&
        (flags_4_q & ~ifeb_pkg::MASK_FLAGS_4) == 16'h0000)
        else $error("reserved bit set in flags two to four");
    a_enable_mask_zero: assert property (@(posedge clock) disable iff (rst)
        (enables_0_q & ~ifeb_pkg::MASK_ENABLES_0) == 16'h0000 &&
        (enables_1_q & ~ifeb_pkg::MASK_ENABLES_1) == 16'h0000 &&
        (enables_2_q & ~ifeb_pkg::MASK_ENABLES_2) == 16'h0000)
        else $error("reserved enable bit set");

    // Pending two follows its flag and enable one cycle later.
    a_pending_two: assert property (@(posedge clock) disable iff (rst)
        ##1 pending_2 == $past(flags_2_q & enables_2_q))
        else $error("pending two wrong");

    // Without a read strobe the data return to zero, so stale data never linger.
    a_read_idle: assert property (@(posedge clock) disable iff (rst)
        !reg_read |=> reg_rdata == 16'h0000)
        else $error("read data not idle");

    // The gap between flag and enable indices reads zero.
    a_unmapped_gap: assert property (@(posedge clock) disable iff (rst)
        reg_read && reg_addr == 4'h7 |=> reg_rdata == 16'h0000)
        else $error("gap index read nonzero");

    // A write to the gap index must not alias onto an enable register.
    a_unmapped_write: assert property (@(posedge clock) disable iff (rst)
        reg_write && reg_addr == 4'h7 |=>
            $stable(enables_0_q) && $stable(enables_1_q) && $stable(enables_2_q))
        else $error("gap write changed an enable");

    // Every implemented source line sets its flag one cycle later.
    a_set_flag_one: assert property (@(posedge clock) disable iff (rst)
        (|src_req_1) |=> (flags_1_q & $past(src_req_1 & ifeb_pkg::MASK_FLAGS_1)) ==
            $past(src_req_1 & ifeb_pkg::MASK_FLAGS_1))
        else $error("flag one missed a request");
    a_set_flag_two: assert property (@(posedge clock) disable iff (rst)
        (|src_req_2) |=> (flags_2_q & $past(src_req_2 & ifeb_pkg::MASK_FLAGS_2)) ==
            $past(src_req_2 & ifeb_pkg::MASK_FLAGS_2))
        else $error("flag two missed a request");
    a_set_flag_three: assert property (@(posedge clock) disable iff (rst)
        (|src_req_3) |=> (flags_3_q & $past(src_req_3 & ifeb_pkg::MASK_FLAGS_3)) ==
            $past(src_req_3 & ifeb_pkg::MASK_FLAGS_3))
        else $error("flag three missed a request");
    a_set_flag_four: assert property (@(posedge clock) disable iff (rst)
        (|src_req_4) |=> (flags_4_q & $past(src_req_4 & ifeb_pkg::MASK_FLAGS_4)) ==
            $past(src_req_4 & ifeb_pkg::MASK_FLAGS_4))
        else $error("flag four missed a request");
    a_set_flag_five: assert property (@(posedge clock) disable iff (rst)
        (|src_req_5) |=> (flags_5_q & $past(src_req_5 & ifeb_pkg::MASK_FLAGS_5)) ==
            $past(src_req_5 & ifeb_pkg::MASK_FLAGS_5))
        else $error("flag five missed a request");

    // In the cycle after reset lifts, no flag may still hold an old event.
    a_reset_flags: assert property (@(posedge clock)
        $fell(rst) |->
            (flags_1_q | flags_2_q | flags_3_q | flags_4_q | flags_5_q) == ifeb_pkg::RESET_VALUE)
        else $error("flag not zero after reset");

    // Enables and pending outputs leave reset at zero, so nothing is requested early.
    a_reset_outputs: assert property (@(posedge clock)
        $fell(rst) |->
            (enables_0_q | enables_1_q | enables_2_q | pending_1 | pending_2) == 16'h0000)
        else $error("enable or pending not zero after reset");

endmodule

`default_nettype wire

/* File: ifeb_pkg.sv */
package ifeb_pkg;

    // Register indices on the plain register port (word addresses).
    localparam logic [3:0] ADDR_FLAGS_1   = 4'h1;
    localparam logic [3:0] ADDR_FLAGS_2   = 4'h2;
    localparam logic [3:0] ADDR_FLAGS_3   = 4'h3;
    localparam logic [3:0] ADDR_FLAGS_4   = 4'h4;
    localparam logic [3:0] ADDR_FLAGS_5   = 4'h5;
    localparam logic [3:0] ADDR_ENABLES_0 = 4'h8;
    localparam logic [3:0] ADDR_ENABLES_1 = 4'h9;
    localparam logic [3:0] ADDR_ENABLES_2 = 4'ha;

    // Implemented-bit masks; every other position is fixed at zero.
    localparam logic [15:0] MASK_FLAGS_1   = 16'hfe1f;
    localparam logic [15:0] MASK_FLAGS_2   = 16'h22e3;
    localparam logic [15:0] MASK_FLAGS_3   = 16'h4006;
    localparam logic [15:0] MASK_FLAGS_4   = 16'h210e;
    localparam logic [15:0] MASK_FLAGS_5   = 16'h0040;
    localparam logic [15:0] MASK_ENABLES_0 = 16'h3fef;
    localparam logic [15:0] MASK_ENABLES_1 = MASK_FLAGS_1;
    localparam logic [15:0] MASK_ENABLES_2 = MASK_FLAGS_2;

    // Power-on value of every implemented bit.
    localparam logic [15:0] RESET_VALUE = 16'h0000;

    // Selected field positions.
    localparam int UART2_TX_FLAG_BIT    = 15;
    localparam int TIMER4_FLAG_BIT      = 11;
    localparam int CAPTURE4_FLAG_BIT    = 6;
    localparam int USB_OTG_FLAG_BIT     = 6;
    localparam int CALENDAR_FLAG_BIT    = 14;
    localparam int ADC_DONE_ENABLE_BIT  = 13;

endpackage

/* File: ifeb_reg16.sv */
`timescale 1ns/10ps
`default_nettype none

module ifeb_reg16 #(
    parameter logic [15:0] MASK = 16'hffff
) (
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        rst,
    // Software write.
    input  wire logic        wr_en,
    input  wire logic [15:0] wr_data,
    // Hardware set pulses, one per bit.
    input  wire logic [15:0] hw_set,
    // Stored value.
    output logic      [15:0] value_q
);

    logic [15:0] value_d;

    // A hardware set wins over a software clear in the same cycle, so no event is lost.
    assign value_d = ((wr_en ? wr_data : value_q) | hw_set) & MASK;

    // Unimplemented bits never leave zero because of the mask.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            value_q <= ifeb_pkg::RESET_VALUE;
        end else begin
            value_q <= value_d;
        end
    end

endmodule

`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    logic        clock;
    logic        rst;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_write;
    logic        reg_read;
    logic [15:0] reg_rdata;
    logic [15:0] sreq [1:5];
    logic [15:0] pending_1;
    logic [15:0] pending_2;
    int          failures;
    int          tests_run;
    localparam logic [3:0] ADR [8] = '{ifeb_pkg::ADDR_FLAGS_1, ifeb_pkg::ADDR_FLAGS_2,
        ifeb_pkg::ADDR_FLAGS_3, ifeb_pkg::ADDR_FLAGS_4, ifeb_pkg::ADDR_FLAGS_5,
        ifeb_pkg::ADDR_ENABLES_0, ifeb_pkg::ADDR_ENABLES_1, ifeb_pkg::ADDR_ENABLES_2};
    localparam logic [15:0] MSK [8] = '{ifeb_pkg::MASK_FLAGS_1, ifeb_pkg::MASK_FLAGS_2,
        ifeb_pkg::MASK_FLAGS_3, ifeb_pkg::MASK_FLAGS_4, ifeb_pkg::MASK_FLAGS_5,
        ifeb_pkg::MASK_ENABLES_0, ifeb_pkg::MASK_ENABLES_1, ifeb_pkg::MASK_ENABLES_2};

    ifeb_bank ifeb_bank_inst (.clock(clock), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .src_req_1(sreq[1]), .src_req_2(sreq[2]),
        .src_req_3(sreq[3]), .src_req_4(sreq[4]), .src_req_5(sreq[5]),
        .pending_1(pending_1), .pending_2(pending_2));

    // Free-running 200 MHz clock.
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Compares one 16-bit result with case equality so unknowns never match.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe on the register port.
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    // One-cycle read; the data stand only in the cycle after the strobe is taken.
    task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    // Every register and an unmapped index read zero after reset.
    task automatic t_reset;
        for (int i = 0; i < 8; i++) rdchk(ADR[i], 16'h0000);
        rdchk(4'h0, 16'h0000);
    endtask

    // All-ones writes keep only the assigned positions; unmapped writes vanish.
    task automatic t_write_all;
        for (int i = 0; i < 8; i++) begin
            wr(ADR[i], 16'hffff);
            rdchk(ADR[i], MSK[i]);
            wr(ADR[i], 16'h0000);
            rdchk(ADR[i], 16'h0000);
        end
        wr(4'h7, 16'hffff);
        rdchk(4'h7, 16'h0000);
    endtask

    // A request pulse on every source line sets exactly the implemented flags.
    task automatic t_sources;
        @(posedge clock);
        for (int k = 1; k <= 5; k++) sreq[k] <= 16'hffff;
        @(posedge clock);
        for (int k = 1; k <= 5; k++) sreq[k] <= 16'h0000;
        for (int i = 0; i < 5; i++) rdchk(ADR[i], MSK[i]);
        for (int i = 0; i < 5; i++) wr(ADR[i], 16'h0000);
        rdchk(ifeb_pkg::ADDR_FLAGS_1, 16'h0000);
    endtask

    // Pending follows flag AND enable, and the flag holds until software clears it.
    // External input one is enabled only together with a driven source line, as a routed pin.
    task automatic t_pending;
        wr(ifeb_pkg::ADDR_ENABLES_1, 16'h0810);
        wr(ifeb_pkg::ADDR_ENABLES_2, 16'h0040);
        @(posedge clock);
        sreq[1] <= 16'h8810;
        sreq[2] <= 16'h00c0;
        @(posedge clock);
        sreq[1] <= 16'h0000;
        sreq[2] <= 16'h0000;
        repeat (6) @(posedge clock);
        #1;
        chk(pending_1, 16'h0810);
        chk(pending_2, 16'h0040);
        wr(ifeb_pkg::ADDR_FLAGS_1, 16'h0000);
        wr(ifeb_pkg::ADDR_ENABLES_2, 16'h0000);
        repeat (2) @(posedge clock);
        #1;
        chk(pending_1, 16'h0000);
        chk(pending_2, 16'h0000);
        rdchk(ifeb_pkg::ADDR_FLAGS_2, 16'h00c0);
    endtask

    // A source request beats a software clear landing on the same edge.
    task automatic t_set_wins;
        @(posedge clock);
        reg_addr  <= ifeb_pkg::ADDR_FLAGS_3;
        reg_wdata <= 16'h0000;
        reg_write <= 1'b1;
        sreq[3]   <= 16'h4000;
        @(posedge clock);
        reg_write <= 1'b0;
        sreq[3]   <= 16'h0000;
        rdchk(ifeb_pkg::ADDR_FLAGS_3, 16'h4000);
    endtask

    // A reset in mid-run clears flags, enables and pending output one alike.
    task automatic t_mid_reset;
        wr(ifeb_pkg::ADDR_FLAGS_1, 16'hffff);
        wr(ifeb_pkg::ADDR_ENABLES_1, 16'hffff);
        @(posedge clock);
        #1;
        chk(pending_1, ifeb_pkg::MASK_ENABLES_1);
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        #1;
        chk(pending_1, 16'h0000);
        for (int i = 0; i < 8; i++) rdchk(ADR[i], 16'h0000);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize;
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main sequence; inputs get values at time zero before reset lifts.
    initial begin
        failures = 0;
        tests_run = 0;
        rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_write = 1'b0;
        reg_read = 1'b0;
        for (int k = 1; k <= 5; k++) sreq[k] = 16'h0000;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_write_all();
        t_sources();
        t_pending();
        t_set_wins();
        t_mid_reset();
        summarize();
    end

    // The tests need well under 1000 cycles, so 20 us means a hang.
    initial begin
        #20000;
        failures++;
        summarize();
    end
endmodule

`default_nettype wire
